// ---- rtl/cmd_host.sv ----
// axi4-lite slave that issues commands and data to the timer
`timescale 1ns/1ps
module cmd_host (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // command port
  cmd_port_if.host port
);
  import timer_cmd_pkg::*;
  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_STB = 3'b010,
    RD_CAP = 3'b100
  } rd_state_t;
  rd_state_t rd_reg;
  logic awHeld, wHeld, doWrite;
  logic [3:0] addr_reg, strb_reg;
  logic [31:0] data_reg;

  assign awready = ce & ~awHeld & ~bvalid;
  assign wready = ce & ~wHeld & ~bvalid;
  assign arready = ce & (rd_reg == RD_IDLE) & ~rvalid;
  assign doWrite = awHeld & wHeld & ~bvalid;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      addr_reg <= 4'h0;
      data_reg <= 32'h0000_0000;
      strb_reg <= 4'h0;
    end else if (ce) begin
      if (awvalid && awready) begin
        awHeld <= 1'b1;
        addr_reg <= awaddr;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld <= 1'b1;
        data_reg <= wdata;
        strb_reg <= wstrb;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
    end
  end

  // one port strobe per accepted write to the command or data offset with wstrb bit 0 set
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      port.wrStb <= 1'b0;
      port.isCmd <= 1'b0;
      port.wrData <= 16'h0000;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (ce) begin
      port.wrStb <= doWrite & strb_reg[0] &
        (addr_reg == ADDR_CMD || addr_reg == ADDR_DATA);
      if (doWrite) begin
        port.isCmd <= addr_reg == ADDR_CMD;
        port.wrData <= data_reg[15:0];
        bvalid <= 1'b1;
        bresp <= (addr_reg == ADDR_CMD || addr_reg == ADDR_DATA) ?
          RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_reg <= RD_IDLE;
      port.rdStb <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (ce) begin
      port.rdStb <= 1'b0;
      if (rvalid && rready)
        rvalid <= 1'b0;
      case (rd_reg)
        RD_IDLE: begin
          if (arvalid && arready) begin
            rresp <= RESP_OKAY;
            rdata <= 32'h0000_0000;
            if (araddr == ADDR_DATA) begin
              port.rdStb <= 1'b1;
              rd_reg <= RD_STB;
            end else begin
              rvalid <= 1'b1;
              if (araddr == ADDR_STAT)
                rdata <= {29'h0, port.seqDisable, port.wideBus,
                  port.freqGateOff};
              else if (araddr != ADDR_CMD)
                rresp <= RESP_SLVERR;
            end
          end
        end
        RD_STB: rd_reg <= RD_CAP;
        RD_CAP: begin
          rdata <= {16'h0000, port.rdData};
          rvalid <= 1'b1;
          rd_reg <= RD_IDLE;
        end
        default: rd_reg <= RD_IDLE;
      endcase
    end
  end
endmodule

// ---- rtl/cmd_port_if.sv ----
// command port between host controller and timing controller
`timescale 1ns/1ps
interface cmd_port_if;
  logic wrStb;
  logic isCmd;
  logic [15:0] wrData;
  logic rdStb;
  logic [15:0] rdData;
  logic seqDisable;
  logic wideBus;
  logic freqGateOff;
  modport device(input wrStb, isCmd, wrData, rdStb,
    output rdData, seqDisable, wideBus, freqGateOff);
  modport host(output wrStb, isCmd, wrData, rdStb,
    input rdData, seqDisable, wideBus, freqGateOff);
endinterface

// ---- rtl/counter_unit.sv ----
// one counter with its mode, load and hold registers
`timescale 1ns/1ps
module counter_unit (
  // clock
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  // pins
  input wire logic srcPin,
  input wire logic gatePin,
  output logic outPin,
  // commands
  input wire logic doArm,
  input wire logic doDisarm,
  input wire logic doSave,
  input wire logic doLoad,
  input wire logic doStep,
  input wire logic doSetOut,
  input wire logic doClrOut,
  input wire logic doReset,
  // register writes and contents
  input wire logic wrMode,
  input wire logic wrLoad,
  input wire logic wrHold,
  input wire logic [15:0] wrData,
  output logic [15:0] modeReg,
  output logic [15:0] loadReg,
  output logic [15:0] holdReg
);
  import timer_cmd_pkg::*;
  logic srcMeta, srcSync, srcLast, gateMeta, gateSync;
  logic armed_reg, pend_reg, tc_reg, toggle_reg;
  logic [15:0] value_reg, value_next;
  logic srcCount, countEv;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      srcMeta <= 1'b0;
      srcSync <= 1'b0;
      srcLast <= 1'b0;
      gateMeta <= 1'b0;
      gateSync <= 1'b0;
    end else if (ce) begin
      srcMeta <= srcPin;
      srcSync <= srcMeta;
      srcLast <= srcSync;
      gateMeta <= gatePin;
      gateSync <= gateMeta;
    end
  end

  assign srcCount = srcSync & ~srcLast & gateSync & armed_reg;
  assign countEv = srcCount | doStep;
  assign value_next = modeReg[CM_DIR] ? value_reg + 16'h0001 :
    value_reg - 16'h0001;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      value_reg <= 16'h0000;
      tc_reg <= 1'b0;
    end else if (ce) begin
      if (doReset) begin
        value_reg <= 16'h0000;
        tc_reg <= 1'b0;
      end else if (doLoad) begin
        value_reg <= loadReg;
        tc_reg <= 1'b0;
      end else if (countEv) begin
        value_reg <= tc_reg ? loadReg : value_next;
        tc_reg <= ~tc_reg & (value_next == 16'h0000);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      armed_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else if (ce) begin
      if (doReset) begin
        armed_reg <= 1'b0;
        pend_reg <= 1'b0;
      end else if (doArm) begin
        armed_reg <= 1'b1;
        pend_reg <= 1'b0;
      end else if (doDisarm && tc_reg) begin
        pend_reg <= 1'b1;
      end else if (doDisarm || (pend_reg && !tc_reg)) begin
        armed_reg <= 1'b0;
        pend_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      modeReg <= CM_RESET;
      loadReg <= 16'h0000;
      holdReg <= 16'h0000;
    end else if (ce) begin
      if (doReset) begin
        modeReg <= CM_RESET;
        loadReg <= 16'h0000;
        holdReg <= 16'h0000;
      end else begin
        if (wrMode)
          modeReg <= wrData;
        if (wrLoad)
          loadReg <= wrData;
        if (doSave)
          holdReg <= value_reg;
        else if (wrHold)
          holdReg <= wrData;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      toggle_reg <= 1'b0;
      outPin <= 1'b0;
    end else if (ce) begin
      if (doReset)
        toggle_reg <= 1'b0;
      else if (doSetOut)
        toggle_reg <= 1'b1;
      else if (doClrOut)
        toggle_reg <= 1'b0;
      outPin <= (modeReg[2:0] == OUT_TC) ? tc_reg : toggle_reg;
    end
  end
endmodule

// ---- rtl/timer_cmd_pkg.sv ----
// constants shared by the command port ends
package timer_cmd_pkg;
  localparam int NCNT = 5;
  // command top bits
  localparam logic [2:0] OP_PTR = 3'h0;
  localparam logic [2:0] OP_ARM = 3'h1;
  localparam logic [2:0] OP_LOAD = 3'h2;
  localparam logic [2:0] OP_LDARM = 3'h3;
  localparam logic [2:0] OP_DISSAVE = 3'h4;
  localparam logic [2:0] OP_SAVE = 3'h5;
  localparam logic [2:0] OP_DISARM = 3'h6;
  localparam logic [2:0] OP_MISC = 3'h7;
  // sub codes under OP_MISC, bits 4:3
  localparam logic [1:0] SUB_CLR = 2'h0;
  localparam logic [1:0] SUB_SET = 2'h1;
  localparam logic [1:0] SUB_STEP = 2'h2;
  // whole-code master mode commands
  localparam logic [7:0] CMD_SEQ_OFF = 8'he8;
  localparam logic [7:0] CMD_SEQ_ON = 8'he0;
  localparam logic [7:0] CMD_WIDE = 8'hef;
  localparam logic [7:0] CMD_NARROW = 8'he7;
  localparam logic [7:0] CMD_DIVIDED_FREQUENCY_OUTPUT_OFF = 8'hee;
  localparam logic [7:0] CMD_DIVIDED_FREQUENCY_OUTPUT_ON = 8'he6;
  localparam logic [7:0] CMD_MRESET = 8'hff;
  // master mode fields
  localparam int MM_SEQ = 14;
  localparam int MM_WIDE = 13;
  localparam int MM_FGATE = 12;
  localparam int MM_DIV_LSB = 8;
  localparam logic [15:0] MM_RESET = 16'h0000;
  // counter mode fields
  localparam int CM_DIR = 3;
  localparam logic [2:0] OUT_TC = 3'h1;
  localparam logic [15:0] CM_RESET = 16'h0b00;
  // data pointer
  localparam logic [2:0] GRP_BAD0 = 3'h0;
  localparam logic [2:0] GRP_BAD1 = 3'h6;
  localparam logic [2:0] GRP_CTRL = 3'h7;
  localparam logic [2:0] GRP_FIRST = 3'h1;
  localparam logic [2:0] GRP_LAST = 3'h5;
  localparam logic [1:0] EL_MODE = 2'h0;
  localparam logic [1:0] EL_LOAD = 2'h1;
  localparam logic [1:0] EL_HOLD = 2'h2;
  // host register offsets
  localparam logic [3:0] ADDR_CMD = 4'h0;
  localparam logic [3:0] ADDR_DATA = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- rtl/timer_command_decoder.sv ----
// command decoder and register access of the five counter timer
//
// Function
// - disarm stops selected counters, deferred while in terminal count
// - counter in terminal count leaves it first
// - disarmed counter still loads, saves, rearms
// - save copies counter value into hold
// - disarm-and-save equals disarm then save
// - set output toggle for counter 1..5
// - clear output toggle for counter 1..5
// - step counts one, direction bit chooses
// - step works on disarmed counter too
// - load pointer element, group, set byte pointer
// - pointer loads only for legal groups
// - code e8 sets sequencing disable bit
// - code e0 clears sequencing disable bit
// - pointer advances unless sequencing disabled or group is control
// - master mode bits writable as whole word
// - code ef selects sixteen bit bus
// - code e7 selects two byte transfers
// - code ee holds frequency output low
// - code e6 drives divided frequency out
// - frequency output may glitch when gated
// - counting needs arming and gate enable
// - master reset clears registers, modes 0b00
`timescale 1ns/1ps
module timer_command_decoder #(
  parameter int NUM_COUNTERS = 5
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  // command port
  cmd_port_if.device port,
  // counter pins
  input wire logic [NUM_COUNTERS-1:0] countSource,
  input wire logic [NUM_COUNTERS-1:0] countGate,
  output logic [NUM_COUNTERS-1:0] counterOutputPin,
  output logic dividedFrequencyOutput
);
  import timer_cmd_pkg::*;

  if (NUM_COUNTERS < 1 || NUM_COUNTERS > NCNT) begin : g_chk
    $error("NUM_COUNTERS must lie in 1..5");
  end

  function automatic logic [NUM_COUNTERS-1:0] numDecode(
    input logic [2:0] n);
    logic [NUM_COUNTERS-1:0] r;
    r = '0;
    for (int i = 0; i < NUM_COUNTERS; i++)
      if (n == 3'(i + 1))
        r[i] = 1'b1;
    return r;
  endfunction

  logic [7:0] cmdCode;
  logic [2:0] opTop;
  logic [NUM_COUNTERS-1:0] sel, numSel, grpHit;
  logic cmdStb, dataWrStb, dataRdStb, isMisc, mreset;
  logic [15:0] mm_reg, lowByte_reg, accWord, rdWord;
  logic [1:0] elem_reg;
  logic [2:0] grp_reg;
  logic bytePtr_reg, accGo, accLast, wide;
  logic [3:0] div_reg;
  logic freqTog_reg;
  logic [NUM_COUNTERS-1:0] cArm, cDis, cSave, cLoad, cStep, cSet, cClr;
  logic [NUM_COUNTERS-1:0] cWrMode, cWrLoad, cWrHold;
  logic [15:0] cMode [NUM_COUNTERS];
  logic [15:0] cLoadR [NUM_COUNTERS];
  logic [15:0] cHold [NUM_COUNTERS];

  // one strobe is one command
  assign cmdStb = port.wrStb & port.isCmd;
  assign dataWrStb = port.wrStb & ~port.isCmd;
  assign dataRdStb = port.rdStb;
  assign cmdCode = port.wrData[7:0];
  assign opTop = cmdCode[7:5];
  assign sel = cmdCode[NUM_COUNTERS-1:0];
  assign isMisc = cmdStb & (opTop == OP_MISC);
  assign mreset = cmdStb & (cmdCode == CMD_MRESET);
  assign numSel = numDecode(cmdCode[2:0]);
  assign grpHit = numDecode(grp_reg);
  assign wide = mm_reg[MM_WIDE];

  assign cArm = (cmdStb && (opTop == OP_ARM || opTop == OP_LDARM)) ?
    sel : '0;
  assign cLoad = (cmdStb && (opTop == OP_LOAD || opTop == OP_LDARM)) ?
    sel : '0;
  assign cDis = (cmdStb && (opTop == OP_DISARM || opTop == OP_DISSAVE)) ?
    sel : '0;
  assign cSave = (cmdStb && (opTop == OP_SAVE || opTop == OP_DISSAVE)) ?
    sel : '0;
  assign cSet = (isMisc && cmdCode[4:3] == SUB_SET) ? numSel : '0;
  assign cClr = (isMisc && cmdCode[4:3] == SUB_CLR) ? numSel : '0;
  assign cStep = (isMisc && cmdCode[4:3] == SUB_STEP) ? numSel : '0;

  // narrow bus: first byte is low half, second completes the word
  assign accWord = wide ? port.wrData : {port.wrData[7:0], lowByte_reg[7:0]};
  assign accLast = wide | ~bytePtr_reg;
  assign accGo = dataWrStb & accLast;
  assign cWrMode = (accGo && elem_reg == EL_MODE) ? grpHit : '0;
  assign cWrLoad = (accGo && elem_reg == EL_LOAD) ? grpHit : '0;
  assign cWrHold = (accGo && elem_reg == EL_HOLD) ? grpHit : '0;

  for (genvar i = 0; i < NUM_COUNTERS; i++) begin : g_cnt
    counter_unit u_cnt (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .ce(ce),
      .srcPin(countSource[i]),
      .gatePin(countGate[i]),
      .outPin(counterOutputPin[i]),
      .doArm(cArm[i]),
      .doDisarm(cDis[i]),
      .doSave(cSave[i]),
      .doLoad(cLoad[i]),
      .doStep(cStep[i]),
      .doSetOut(cSet[i]),
      .doClrOut(cClr[i]),
      .doReset(mreset),
      .wrMode(cWrMode[i]),
      .wrLoad(cWrLoad[i]),
      .wrHold(cWrHold[i]),
      .wrData(accWord),
      .modeReg(cMode[i]),
      .loadReg(cLoadR[i]),
      .holdReg(cHold[i])
    );
  end

  // master mode register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mm_reg <= MM_RESET;
    end else if (ce) begin
      if (mreset)
        mm_reg <= MM_RESET;
      else if (accGo && grp_reg == GRP_CTRL && elem_reg == EL_MODE)
        mm_reg <= accWord;
      else if (isMisc) begin
        case (cmdCode)
          CMD_SEQ_OFF: mm_reg[MM_SEQ] <= 1'b1;
          CMD_SEQ_ON: mm_reg[MM_SEQ] <= 1'b0;
          CMD_WIDE: mm_reg[MM_WIDE] <= 1'b1;
          CMD_NARROW: mm_reg[MM_WIDE] <= 1'b0;
          CMD_DIVIDED_FREQUENCY_OUTPUT_OFF: mm_reg[MM_FGATE] <= 1'b1;
          CMD_DIVIDED_FREQUENCY_OUTPUT_ON: mm_reg[MM_FGATE] <= 1'b0;
          default: mm_reg <= mm_reg;
        endcase
      end
    end
  end

  // data pointer
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      elem_reg <= EL_MODE;
      grp_reg <= GRP_FIRST;
      bytePtr_reg <= 1'b1;
      lowByte_reg <= 16'h0000;
    end else if (ce) begin
      if (cmdStb && opTop == OP_PTR) begin
        if (cmdCode[2:0] != GRP_BAD0 && cmdCode[2:0] != GRP_BAD1) begin
          elem_reg <= cmdCode[4:3];
          grp_reg <= cmdCode[2:0];
          bytePtr_reg <= 1'b1;
        end
      end else if (dataWrStb || dataRdStb) begin
        if (!wide && bytePtr_reg) begin
          bytePtr_reg <= 1'b0;
          lowByte_reg <= {8'h00, port.wrData[7:0]};
        end else begin
          bytePtr_reg <= 1'b1;
          if (!mm_reg[MM_SEQ] && grp_reg != GRP_CTRL) begin
            if (elem_reg != EL_HOLD) begin
              elem_reg <= elem_reg + 2'h1;
            end else begin
              elem_reg <= EL_MODE;
              grp_reg <= (grp_reg == GRP_LAST) ? GRP_FIRST :
                grp_reg + 3'h1;
            end
          end
        end
      end
    end
  end

  always_comb begin
    rdWord = 16'h0000;
    if (grp_reg == GRP_CTRL && elem_reg == EL_MODE)
      rdWord = mm_reg;
    for (int i = 0; i < NUM_COUNTERS; i++)
      if (grpHit[i])
        case (elem_reg)
          EL_MODE: rdWord = cMode[i];
          EL_LOAD: rdWord = cLoadR[i];
          EL_HOLD: rdWord = cHold[i];
          default: rdWord = 16'h0000;
        endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      port.rdData <= 16'h0000;
    else if (ce && dataRdStb)
      port.rdData <= wide ? rdWord :
        {8'h00, bytePtr_reg ? rdWord[7:0] : rdWord[15:8]};
  end

  // frequency divider, ratio 0 meaning sixteen
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 4'h0;
      freqTog_reg <= 1'b0;
      dividedFrequencyOutput <= 1'b0;
    end else if (ce) begin
      if (div_reg == mm_reg[MM_DIV_LSB+:4] - 4'h1) begin
        div_reg <= 4'h0;
        freqTog_reg <= ~freqTog_reg;
      end else begin
        div_reg <= div_reg + 4'h1;
      end
      dividedFrequencyOutput <= ~mm_reg[MM_FGATE] & freqTog_reg;
    end
  end

  assign port.seqDisable = mm_reg[MM_SEQ];
  assign port.wideBus = mm_reg[MM_WIDE];
  assign port.freqGateOff = mm_reg[MM_FGATE];
endmodule

// ---- verification/timer_command_decoder_monitor.sv ----
// concurrent checks on the command port between host and decoder
`timescale 1ns/1ps
module timer_command_decoder_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // command port
  input wire logic wrStb,
  input wire logic isCmd,
  input wire logic [15:0] wrData,
  input wire logic seqDisable,
  input wire logic wideBus,
  input wire logic freqGateOff
);
  import timer_cmd_pkg::*;
  logic [2:0] mmBits;
  assign mmBits = {seqDisable, wideBus, freqGateOff};
  default clocking mon_cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence cmdS(logic [7:0] code);
    wrStb && isCmd && wrData[7:0] == code;
  endsequence
  sequence quietS;
    !wrStb;
  endsequence
  AST_SEQ_SET: assert property (
    cmdS(CMD_SEQ_OFF) |=> seqDisable && $stable({wideBus, freqGateOff}))
    else $error("sequencing disable not set alone");
  AST_SEQ_CLR: assert property (
    cmdS(CMD_SEQ_ON) |=> !seqDisable && $stable({wideBus, freqGateOff}))
    else $error("sequencing disable not cleared alone");
  AST_WIDE_SET: assert property (
    cmdS(CMD_WIDE) ##1 1'b1 |-> wideBus && $stable(seqDisable))
    else $error("wide bus not selected");
  AST_WIDE_CLR: assert property (
    cmdS(CMD_NARROW) ##1 1'b1 |-> !wideBus && $stable(freqGateOff))
    else $error("narrow bus not selected");
  AST_FGATE_SET: assert property (
    cmdS(CMD_DIVIDED_FREQUENCY_OUTPUT_OFF) |=> freqGateOff && $stable({seqDisable, wideBus}))
    else $error("frequency gate not set");
  AST_FGATE_CLR: assert property (
    cmdS(CMD_DIVIDED_FREQUENCY_OUTPUT_ON) |=> !freqGateOff && $stable({seqDisable, wideBus}))
    else $error("frequency gate not cleared");
  AST_MRESET: assert property (
    cmdS(CMD_MRESET) |=> mmBits == 3'h0)
    else $error("master reset left mode bits set");
  AST_QUIET: assert property (
    quietS |=> $stable(mmBits))
    else $error("mode bits moved without a write");
  AST_UNUSED: assert property (
    wrStb && isCmd && wrData[7:0] inside {8'h00, 8'h06, 8'hf0, 8'hf6,
      8'hf7, [8'hf8:8'hfe]} |=> $stable(mmBits))
    else $error("unassigned code changed mode bits");
  AST_OTHER_OPS: assert property (
    wrStb && isCmd && wrData[7:5] != OP_MISC |=> $stable(mmBits))
    else $error("counter command changed mode bits");
endmodule

// ---- verification/timer_command_decoder_tb.sv ----
// testbench for the timer command decoder and its axi4-lite host
`timescale 1ns/1ps
module timer_command_decoder_tb;
  import timer_cmd_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, r;
  logic awready, wready, bvalid, arready, rvalid, freqOut;
  logic [1:0] bresp, rresp;
  logic [4:0] countSource, countGate, outPins, e;
  logic seqM, wideM, fgM;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [33:0] re;
  int miscompares = 0;
  int numChecks = 0;
  int n, k;
  logic [7:0] codes [0:14] = '{8'he8, 8'hef, 8'hf0, 8'hee, 8'hf6, 8'he0,
    8'h06, 8'he7, 8'hf7, 8'he6, 8'hfa, 8'he8, 8'hef, 8'hee, 8'hff};
  always #12.5 ref_clk = ~ref_clk;
  cmd_port_if cmd_port_if_inst ();
  cmd_host cmd_host_inst (.ref_clk(ref_clk), .rstn(rstn), .ce(1'b1),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .port(cmd_port_if_inst));
  timer_command_decoder #(.NUM_COUNTERS(5)) timer_command_decoder_inst (
    .ref_clk(ref_clk), .rstn(rstn), .ce(1'b1), .port(cmd_port_if_inst),
    .countSource(countSource), .countGate(countGate),
    .counterOutputPin(outPins), .dividedFrequencyOutput(freqOut));
  timer_command_decoder_monitor timer_command_decoder_monitor_inst (
    .ref_clk(ref_clk), .rstn(rstn), .wrStb(cmd_port_if_inst.wrStb),
    .isCmd(cmd_port_if_inst.isCmd), .wrData(cmd_port_if_inst.wrData),
    .seqDisable(cmd_port_if_inst.seqDisable),
    .wideBus(cmd_port_if_inst.wideBus),
    .freqGateOff(cmd_port_if_inst.freqGateOff));
  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d miscompares %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
    input logic [1:0] rs);
    int t;
    @(posedge ref_clk);
    bq.push_back(rs);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    t = 0;
    do begin
      @(posedge ref_clk);
      t++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid === 1'b1) && t < 60);
    bready <= 1'b0;
    if (t >= 60) begin
      miscompares++;
      close_out();
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] d,
    input logic [1:0] rs);
    int t;
    @(posedge ref_clk);
    rq.push_back({rs, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    t = 0;
    do begin
      @(posedge ref_clk);
      t++;
      if (arready) arvalid <= 1'b0;
    end while (!(rvalid === 1'b1) && t < 60);
    rready <= 1'b0;
    if (t >= 60) begin
      miscompares++;
      close_out();
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    wr(ADDR_CMD, {24'h0, c}, RESP_OKAY);
    case (c)
      CMD_SEQ_OFF: seqM = 1'b1;
      CMD_SEQ_ON: seqM = 1'b0;
      CMD_WIDE: wideM = 1'b1;
      CMD_NARROW: wideM = 1'b0;
      CMD_DIVIDED_FREQUENCY_OUTPUT_OFF: fgM = 1'b1;
      CMD_DIVIDED_FREQUENCY_OUTPUT_ON: fgM = 1'b0;
      CMD_MRESET: {seqM, wideM, fgM} = 3'h0;
      default: ;
    endcase
  endtask
  task automatic st();
    rd(ADDR_STAT, {29'h0, seqM, wideM, fgM}, RESP_OKAY);
  endtask
  task automatic dat(input logic [15:0] d);
    if (wideM) wr(ADDR_DATA, {16'h0, d}, RESP_OKAY);
    else begin
      wr(ADDR_DATA, {24'h0, d[7:0]}, RESP_OKAY);
      wr(ADDR_DATA, {24'h0, d[15:8]}, RESP_OKAY);
    end
  endtask
  task automatic rdw(input logic [15:0] d);
    if (wideM) rd(ADDR_DATA, {16'h0, d}, RESP_OKAY);
    else begin
      rd(ADDR_DATA, {24'h0, d[7:0]}, RESP_OKAY);
      rd(ADDR_DATA, {24'h0, d[15:8]}, RESP_OKAY);
    end
  endtask
  task automatic pulse(input int p);
    repeat (p) begin
      @(posedge ref_clk);
      countSource[2] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      countSource[2] <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
    repeat (6) @(posedge ref_clk);
  endtask
  // results are compared in arrival order
  always @(posedge ref_clk) begin
    if (bvalid === 1'b1 && bready && bq.size() > 0) begin
      chk("bresp", {30'h0, bresp}, {30'h0, bq.pop_front()});
    end
    if (rvalid === 1'b1 && rready && rq.size() > 0) begin
      re = rq.pop_front();
      chk("rdata", rdata, re[31:0]);
      chk("rresp", {30'h0, rresp}, {30'h0, re[33:32]});
    end
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 40'h0;
    wstrb = 4'hf;
    countSource = 5'h00;
    countGate = 5'h04;
    {seqM, wideM, fgM} = 3'h0;
    void'($urandom(32));
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    st();
    foreach (codes[i]) begin
      cmd(codes[i]);
      st();
    end
    // whole master mode word through the data port
    cmd(8'h07);
    cmd(8'h06);
    dat(16'h7000);
    {seqM, wideM, fgM} = 3'h7;
    st();
    n = 0;
    repeat (64) begin
      @(posedge ref_clk);
      if (freqOut !== 1'b0) n++;
    end
    chk("divided_frequency_output low", n, 0);
    dat(16'h4000);
    {seqM, wideM, fgM} = 3'h4;
    st();
    rdw(16'h4000);
    n = 0;
    repeat (80) begin
      @(posedge ref_clk);
      if (freqOut === 1'b1) n++;
    end
    chk("divided_frequency_output runs", {31'h0, n > 8 && n < 72}, 32'h1);
    // pointer held, then advancing
    cmd(CMD_WIDE);
    cmd(8'h09);
    r = $urandom;
    dat(16'h1234);
    dat(r[15:0]);
    rdw(r[15:0]);
    rdw(r[15:0]);
    cmd(CMD_SEQ_ON);
    r = $urandom;
    cmd(8'h09);
    dat(r[15:0]);
    dat(r[31:16]);
    cmd(8'h09);
    rdw(r[15:0]);
    rdw(r[31:16]);
    // step and save on a disarmed counter
    cmd(8'h09);
    dat(16'd5);
    cmd(8'h41);
    cmd(8'hf1);
    cmd(8'ha1);
    cmd(8'h11);
    rdw(16'd4);
    cmd(8'h01);
    dat(16'h0b08);
    cmd(8'hf1);
    cmd(8'hf1);
    cmd(8'h81);
    cmd(8'h11);
    rdw(16'd6);
    // counter 3 counts source edges only while armed
    k = ($urandom % 8) + 1;
    cmd(8'h0b);
    dat(16'd100);
    cmd(8'h44);
    pulse(k);
    cmd(8'ha4);
    cmd(8'h13);
    rdw(16'd100);
    cmd(8'h24);
    pulse(k);
    cmd(8'ha4);
    cmd(8'h13);
    rdw(16'(100 - k));
    cmd(8'hc4);
    pulse(3);
    cmd(8'ha4);
    cmd(8'h13);
    rdw(16'(100 - k));
    // disarm in terminal count waits for one more count
    cmd(8'h0b);
    dat(16'd1);
    cmd(8'h64);
    cmd(8'hf3);
    cmd(8'hc4);
    pulse(3);
    cmd(8'ha4);
    cmd(8'h13);
    rdw(16'd1);
    // output toggles set and cleared one by one
    e = 5'h00;
    for (int i = 1; i <= 10; i++) begin
      if (i <= 5) cmd(8'he8 | 8'(i));
      else cmd(8'he0 | 8'(i - 5));
      e[(i - 1) % 5] = (i <= 5);
      repeat (3) @(posedge ref_clk);
      #1;
      chk("outputs", {27'h0, outPins}, {27'h0, e});
    end
    // master reset restores counter modes and outputs
    cmd(CMD_MRESET);
    cmd(8'h01);
    rdw(CM_RESET);
    chk("outputs", {27'h0, outPins}, 32'h0);
    // bus corner cases
    wr(4'hc, 32'h0, RESP_SLVERR);
    rd(4'hc, 32'h0, RESP_SLVERR);
    rd(ADDR_CMD, 32'h0, RESP_OKAY);
    wstrb <= 4'h0;
    wr(ADDR_CMD, 32'he8, RESP_OKAY);
    wstrb <= 4'hf;
    st();
    repeat (4) @(posedge ref_clk);
    chk("pending", bq.size() + rq.size(), 0);
    close_out();
  end
endmodule
